// ===== vic_cfg.svh
// Constants of the vectored interrupt controller: offsets, fields, resets and timing
`ifndef VIC_CFG_SVH
`define VIC_CFG_SVH
// Register byte offsets on the bus
`define VIC_OFS_CTRL 8'h00
`define VIC_OFS_ENAB 8'h04
`define VIC_OFS_STATE 8'h08
`define VIC_OFS_STAT 8'h0c
`define VIC_OFS_CLR 8'h10
`define VIC_OFS_IEN 8'h14
// Control register fields
`define VIC_CTRL_EDGE_LSB 0
`define VIC_CTRL_PIN_EN 2
`define VIC_CTRL_RST 3'h0
// Enable bit positions inside each 4-bit enable register
`define VIC_EN1_EXT 0
`define VIC_EN1_TMA 2
`define VIC_EN1_TMB 3
`define VIC_EN2_CONV 2
`define VIC_EN2_SER 3
`define VIC_EN_RST 4'h0
// Page 1 base and vector offsets
`define VIC_PAGE1 12'h080
`define VIC_VEC_EXT 12'h000
`define VIC_VEC_TMA 12'h004
`define VIC_VEC_TMB 12'h006
`define VIC_VEC_CONV 12'h00c
`define VIC_VEC_SER 12'h00e
// Entry latency in machine cycles
`define VIC_LAT_SHORT 2'h2
`define VIC_LAT_LONG 2'h3
// Event bits of the status register
`define VIC_EV_TAKE 0
`define VIC_EV_SKIP 1
`define VIC_EV_RET 2
`define VIC_EV_W 3
`define VIC_CTX_W 20
`endif

// ===== vic_pkg.sv
// Types shared by the vectored interrupt controller
package vic_pkg;
  // Entry sequencer, Gray coded along idle, wait, take
  typedef enum logic [1:0] {
    VIC_IDLE = 2'b00,
    VIC_WAIT = 2'b01,
    VIC_TAKE = 2'b11
  } vic_state_t;
  // One bit per source: ext, timer a, timer b, converter, serial
  typedef logic [4:0] vic_src_t;
endpackage

// ===== vic_ctx_store.sv
// Single-level context save register for interrupt entry
module vic_ctx_store
  import vic_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Write side
  input wire logic i_wr,
  input wire logic [19:0] i_wdata,
  // Read side, straight from the storage flops
  output logic [19:0] o_rdata
);
  // One stage only: a nested entry overwrites the saved context
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata <= 20'h00000;
    end else if (i_wr) begin
      o_rdata <= i_wdata;
    end
  end
endmodule

// ===== vic_top.sv
// Vectored interrupt controller with AHB-Lite register access
`include "vic_cfg.svh"
// How it works
// - Take only when flag, enable, global all set
// - Branch to fixed page-1 vector per source
// - Pending sources served external, timers, converter, serial
// - Enable instruction sets, disable instruction clears global
// - Taking any interrupt clears global enable
// - Enable bit selects interrupt or skip test
// - Flags set even while interrupt blocked
// - Flag clears on take or successful skip
// - Flags hold until a clear condition
// - Entry clears only the serviced source flag
// - Entry loads vector, pushes return address
// - Entry saves pointer, carry, skip, A, B
// - Enable instruction acts after one more instruction
// - Entry follows two or three machine cycles
module vic_top
  import vic_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Request sources
  input wire logic i_ext_pin,
  input wire logic i_tmr_a_uflow,
  input wire logic i_tmr_b_uflow,
  input wire logic i_conv_done,
  input wire logic i_serial_done,
  // Core sequencer strobes
  input wire logic i_mcyc,
  input wire logic i_one_cycle_instr,
  input wire logic i_instr_done,
  input wire logic i_enable_irq_instr,
  input wire logic i_disable_irq_instr,
  input wire logic i_return_from_irq_instr,
  input wire logic [4:0] i_skip_test,
  input wire logic i_en_wr_one,
  input wire logic i_en_wr_two,
  input wire logic [3:0] i_acc,
  input wire logic [11:0] i_pc,
  input wire logic [19:0] i_ctx,
  // Core sequencer results
  output logic o_irq_take,
  output logic [11:0] o_vector,
  output logic [11:0] o_ret_addr,
  output logic o_skip,
  output logic [19:0] o_ctx,
  output logic o_ctx_restore,
  output logic [3:0] o_irq_enable_reg_one,
  output logic [3:0] o_irq_enable_reg_two,
  output logic o_global_irq_enable,
  // System interrupt
  output logic o_irq
);
  // Lowest index wins: external first, serial last
  function automatic vic_src_t pick(input vic_src_t req);
    pick = req & ~(req - 5'h01);
  endfunction
  // Page-1 address of the one-hot source
  function automatic logic [11:0] vec_of(input vic_src_t s);
    vec_of = `VIC_PAGE1 | (s[0] ? `VIC_VEC_EXT : s[1] ? `VIC_VEC_TMA :
      s[2] ? `VIC_VEC_TMB : s[3] ? `VIC_VEC_CONV : `VIC_VEC_SER);
  endfunction

  vic_state_t state; // Entry sequencer
  vic_state_t next_state;
  vic_src_t flags; // Request flags
  vic_src_t src_q; // Source latched for entry
  logic [1:0] mc_cnt; // Machine cycles since conditions met
  logic [1:0] lat_q; // Latency chosen at detection
  logic ei_pend; // Enable instruction waiting one instruction
  logic [2:0] ctrl; // Edge select and pin enable
  logic [2:0] stat; // Sticky events
  logic [2:0] ien; // Event interrupt enables
  logic pin_s1, pin_s2, pin_s3; // Pin synchroniser and history
  logic wr_q; // Bus write in data phase
  logic [7:0] waddr_q; // Bus write address

  // Pin passes two flops; third flop holds the previous level
  always_ff @(posedge i_mclk) begin
    pin_s1 <= i_ext_pin;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
  end

  // Edge select: 00 falling, 01 rising, 1x both
  wire rise = pin_s2 & ~pin_s3;
  wire fall = ~pin_s2 & pin_s3;
  wire [1:0] esel = ctrl[`VIC_CTRL_EDGE_LSB +: 2];
  wire ext_ev = ctrl[`VIC_CTRL_PIN_EN] & (esel[1] ? (rise | fall) : esel[0] ? rise : fall);
  wire [4:0] set_ev = {i_serial_done, i_conv_done, i_tmr_b_uflow, i_tmr_a_uflow, ext_ev};

  // Per-source enables gathered from both enable registers
  wire [4:0] src_en = {o_irq_enable_reg_two[`VIC_EN2_SER], o_irq_enable_reg_two[`VIC_EN2_CONV],
    o_irq_enable_reg_one[`VIC_EN1_TMB], o_irq_enable_reg_one[`VIC_EN1_TMA],
    o_irq_enable_reg_one[`VIC_EN1_EXT]};
  wire [4:0] ready_req = flags & src_en;
  wire start = (state == VIC_IDLE) & i_mcyc & o_global_irq_enable & (|ready_req);
  wire [4:0] skip_hit = i_skip_test & ~src_en & flags;
  wire take_now = (state == VIC_TAKE);
  wire [4:0] take_clr = take_now ? src_q : 5'h00;

  // Set wins over clear so an event in the clearing cycle survives
  wire [4:0] next_flags = set_ev | (flags & ~(take_clr | skip_hit));

  // Sequencer transitions; latency counted in machine cycles
  always_comb begin
    next_state = state;
    case (state)
      VIC_IDLE: begin
        if (start) begin
          next_state = VIC_WAIT;
        end
      end
      VIC_WAIT: begin
        if (i_mcyc && (mc_cnt + 2'h1 == lat_q)) begin
          next_state = VIC_TAKE;
        end
      end
      VIC_TAKE: next_state = VIC_IDLE;
      default: next_state = VIC_IDLE;
    endcase
  end

  // Sequencer state, latency and latched source
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state <= VIC_IDLE;
      src_q <= 5'h00;
      mc_cnt <= 2'h0;
      lat_q <= `VIC_LAT_LONG;
    end else begin
      state <= next_state;
      if (start) begin
        src_q <= pick(ready_req);
        lat_q <= i_one_cycle_instr ? `VIC_LAT_SHORT : `VIC_LAT_LONG;
        mc_cnt <= 2'h0;
      end else if (state == VIC_WAIT && i_mcyc) begin
        mc_cnt <= mc_cnt + 2'h1;
      end
    end
  end

  // Request flags
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      flags <= 5'h00;
    end else begin
      flags <= next_flags;
    end
  end

  // Global enable: entry and disable act at once, enable after one more instruction
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_global_irq_enable <= 1'b0;
      ei_pend <= 1'b0;
    end else if (take_now || i_disable_irq_instr) begin
      o_global_irq_enable <= 1'b0;
      ei_pend <= 1'b0;
    end else if (i_enable_irq_instr) begin
      ei_pend <= 1'b1;
    end else if (ei_pend && i_instr_done) begin
      o_global_irq_enable <= 1'b1;
      ei_pend <= 1'b0;
    end
  end

  // Entry strobe, vector and return address to the sequencer
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_irq_take <= 1'b0;
      o_vector <= `VIC_PAGE1;
      o_ret_addr <= 12'h000;
      o_skip <= 1'b0;
      o_ctx_restore <= 1'b0;
    end else begin
      o_irq_take <= take_now;
      o_skip <= |skip_hit;
      o_ctx_restore <= i_return_from_irq_instr;
      if (take_now) begin
        o_vector <= vec_of(src_q);
        o_ret_addr <= i_pc;
      end
    end
  end

  // Context is captured on the same edge as the entry strobe
  vic_ctx_store u_ctx (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_wr(take_now),
    .i_wdata(i_ctx),
    .o_rdata(o_ctx)
  );

  // Bus decode: address phase taken when selected and ready
  wire addr_ok = i_hsel & i_htrans[1] & i_hready;
  wire [7:0] ra = i_haddr[7:0];
  wire do_wr = wr_q;
  wire [31:0] rd_mux =
    (ra == `VIC_OFS_CTRL) ? {29'h0, ctrl} :
    (ra == `VIC_OFS_ENAB) ? {24'h0, o_irq_enable_reg_two, o_irq_enable_reg_one} :
    (ra == `VIC_OFS_STATE) ? {21'h0, state, lat_q, ei_pend, o_global_irq_enable, flags} :
    (ra == `VIC_OFS_STAT) ? {29'h0, stat} :
    (ra == `VIC_OFS_IEN) ? {29'h0, ien} : 32'h0;
  wire [2:0] ev = {o_ctx_restore, o_skip, o_irq_take};
  wire [2:0] clr_w = (do_wr && waddr_q == `VIC_OFS_CLR) ? i_hwdata[2:0] : 3'h0;

  // Bus phases; zero wait states, always OKAY
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
      o_hrdata <= 32'h0;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      wr_q <= addr_ok & i_hwrite;
      waddr_q <= ra;
      if (addr_ok && !i_hwrite) begin
        o_hrdata <= rd_mux;
      end
    end
  end

  // Writable registers; the core's transfer wins over a bus write
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ctrl <= `VIC_CTRL_RST;
      ien <= 3'h0;
      o_irq_enable_reg_one <= `VIC_EN_RST;
      o_irq_enable_reg_two <= `VIC_EN_RST;
    end else begin
      if (do_wr && waddr_q == `VIC_OFS_CTRL) begin
        ctrl <= i_hwdata[2:0];
      end
      if (do_wr && waddr_q == `VIC_OFS_IEN) begin
        ien <= i_hwdata[2:0];
      end
      if (i_en_wr_one) begin
        o_irq_enable_reg_one <= i_acc;
      end else if (do_wr && waddr_q == `VIC_OFS_ENAB) begin
        o_irq_enable_reg_one <= i_hwdata[3:0];
      end
      if (i_en_wr_two) begin
        o_irq_enable_reg_two <= i_acc;
      end else if (do_wr && waddr_q == `VIC_OFS_ENAB) begin
        o_irq_enable_reg_two <= i_hwdata[7:4];
      end
    end
  end

  // Sticky events: a new event beats a clear in the same cycle
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      stat <= 3'h0;
      o_irq <= 1'b0;
    end else begin
      stat <= ev | (stat & ~clr_w);
      o_irq <= |((ev | (stat & ~clr_w)) & ien);
    end
  end

  // Checks
  a_take_needs_all: assert property (@(posedge i_mclk) disable iff (i_rst)
    start |-> (|(flags & src_en)) && o_global_irq_enable)
    else $error("entry started without all three conditions");
  a_vector_value: assert property (@(posedge i_mclk) disable iff (i_rst)
    take_now |=> o_irq_take && o_vector == vec_of($past(src_q)))
    else $error("wrong vector on entry");
  a_fixed_priority: assert property (@(posedge i_mclk) disable iff (i_rst)
    start |=> src_q == ($past(ready_req) & ~($past(ready_req) - 5'h01)))
    else $error("priority not honoured");
  a_disable_clears: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_disable_irq_instr |=> !o_global_irq_enable)
    else $error("disable instruction left global enable set");
  a_take_drops_gie: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_irq_take |-> !o_global_irq_enable ##1 !o_global_irq_enable)
    else $error("global enable survived entry");
  a_skip_blocked: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_skip_test != 5'h00 && (i_skip_test & ~src_en) == 5'h00) |=> !o_skip)
    else $error("skip taken while interrupt enabled");
  a_flag_sets: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_tmr_a_uflow |=> flags[1])
    else $error("timer flag not set");
  a_only_src_clear: assert property (@(posedge i_mclk) disable iff (i_rst)
    take_now && (skip_hit == 5'h00) |=>
      (flags & ~$past(src_q)) == ($past(flags | set_ev) & ~$past(src_q)))
    else $error("entry disturbed another flag");
  a_ctx_saved: assert property (@(posedge i_mclk) disable iff (i_rst)
    take_now |=> o_ctx == $past(i_ctx) && o_ret_addr == $past(i_pc))
    else $error("context or return address not saved");
  a_ei_delayed: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_enable_irq_instr && !o_global_irq_enable && !i_disable_irq_instr && !take_now
      |=> !o_global_irq_enable)
    else $error("enable took effect at once");
  a_latency_bound: assert property (@(posedge i_mclk) disable iff (i_rst)
    state == VIC_WAIT |-> mc_cnt < lat_q)
    else $error("entry latency overrun");
  c_entry: cover property (@(posedge i_mclk) disable iff (i_rst) o_irq_take);
  c_skip: cover property (@(posedge i_mclk) disable iff (i_rst) o_skip);
  c_two_pending: cover property (@(posedge i_mclk) disable iff (i_rst)
    start && $countones(ready_req) > 1);
  c_short_lat: cover property (@(posedge i_mclk) disable iff (i_rst)
    start && i_one_cycle_instr);
endmodule

// ===== vic_core_model.sv
// Behavioural core sequencer that paces machine cycles and returns from service
module vic_core_model (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Pacing choice and entry strobe
  input wire logic i_slow,
  input wire logic i_irq_take,
  // Sequencer strobes
  output logic o_mcyc,
  output logic o_instr_done,
  output logic o_one_cycle,
  output logic o_ret
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cyc; // Clocks left in this machine cycle
  logic [2:0] svc; // Clocks left in the service routine
  // Slow pacing means multi-cycle instructions, so entry takes the longer path
  assign o_one_cycle = ~i_slow;
  // Strobes are registered so the controller never sees them mid-cycle
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cyc <= 2'h0;
      svc <= 3'h0;
      o_mcyc <= 1'b0;
      o_instr_done <= 1'b0;
      o_ret <= 1'b0;
    end else begin
      o_mcyc <= (cyc == 2'h0);
      o_instr_done <= (cyc == 2'h0);
      cyc <= (cyc != 2'h0) ? cyc - 2'h1 : (i_slow ? 2'h3 : 2'h1);
      // Each routine ends with the return instruction a few clocks after entry
      o_ret <= (svc == 3'h1);
      svc <= i_irq_take ? 3'h6 : ((svc != 3'h0) ? svc - 3'h1 : 3'h0);
    end
  end
endmodule

// ===== vectored_interrupt_controller_test.sv
// Self-checking bench for the vectored interrupt controller
`include "vic_cfg.svh"
module vectored_interrupt_controller_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, ext_pin = 0, ei = 0, di = 0, wr1 = 0, wr2 = 0;
  logic slow = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [3:0] src = 0, acc = 0;
  logic [4:0] skp = 0, m;
  logic [11:0] pc = 0;
  logic [19:0] ctx = 0;
  // Observed outputs
  logic [31:0] hrdata;
  logic hrdy, hresp, take, oskip, restore, gie, irq, mcyc, idone, onec, ret;
  logic [11:0] vec, raddr;
  logic [19:0] octx;
  logic [3:0] en1, en2;
  int mismatches = 0, n_checks = 0, cycles = 0, cnt, n_rest = 0, n_take = 0, t0;
  initial begin
    forever #2 clk = ~clk;
  end
  vic_top dut (.i_mclk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
    .o_hreadyout(hrdy), .o_hresp(hresp), .i_ext_pin(ext_pin), .i_tmr_a_uflow(src[0]),
    .i_tmr_b_uflow(src[1]), .i_conv_done(src[2]), .i_serial_done(src[3]), .i_mcyc(mcyc),
    .i_one_cycle_instr(onec), .i_instr_done(idone), .i_enable_irq_instr(ei),
    .i_disable_irq_instr(di), .i_return_from_irq_instr(ret), .i_skip_test(skp),
    .i_en_wr_one(wr1), .i_en_wr_two(wr2), .i_acc(acc), .i_pc(pc), .i_ctx(ctx),
    .o_irq_take(take), .o_vector(vec), .o_ret_addr(raddr), .o_skip(oskip), .o_ctx(octx),
    .o_ctx_restore(restore), .o_irq_enable_reg_one(en1), .o_irq_enable_reg_two(en2),
    .o_global_irq_enable(gie), .o_irq(irq));
  vic_core_model core (.i_mclk(clk), .i_rst(rst), .i_slow(slow), .i_irq_take(take),
    .o_mcyc(mcyc), .o_instr_done(idone), .o_one_cycle(onec), .o_ret(ret));
  // Value compare, counted
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Wait edges, then step past them so outputs are settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One AHB single transfer; the wait on ready is open-ended, the timeout bounds it
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  // Source pulses; the pin toggles so either edge counts
  task automatic pulse_src(input logic [3:0] s, input logic e);
    @(posedge clk);
    src <= s;
    if (e) ext_pin <= ~ext_pin;
    @(posedge clk);
    src <= 4'h0;
    tick(6);
  endtask
  // Core loads both enable registers from the accumulator
  task automatic set_en(input logic [3:0] one, input logic [3:0] two);
    @(posedge clk);
    acc <= one;
    wr1 <= 1'b1;
    @(posedge clk);
    wr1 <= 1'b0;
    acc <= two;
    wr2 <= 1'b1;
    @(posedge clk);
    wr2 <= 1'b0;
  endtask
  // Vector of the k-th source in priority order
  function automatic logic [11:0] exp_vec(input int k);
    logic [11:0] t [5] = '{12'h080, 12'h084, 12'h086, 12'h08c, 12'h08e};
    return t[k];
  endfunction
  // Flags still pending once the first k+1 sources have been served
  function automatic logic [31:0] left_after(input int k);
    return 32'h1f & (32'h1f << (k + 1));
  endfunction
  // Machine cycles from condition to entry
  function automatic int exp_lat(input logic one);
    return one ? 2 : 3;
  endfunction
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Event counters and the hang guard
  always @(posedge clk) begin
    cycles++;
    if (restore === 1'b1) n_rest++;
    if (take === 1'b1) n_take++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(31));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    check("vector", 32'h080, {20'h0, vec});
    check("global enable", 0, gie);
    ahb(1'b0, `VIC_OFS_STATE, 0);
    check("reset flags", 0, rd & 32'h3f);
    check("response", 0, hresp);
    // Blocked sources still latch and hold their flags
    ahb(1'b1, `VIC_OFS_CTRL, 32'h6);
    m = 5'($urandom) | 5'h1;
    pulse_src(m[4:1], 1'b1);
    tick(20);
    ahb(1'b0, `VIC_OFS_STATE, 0);
    check("held flags", {27'h0, m}, rd & 32'h1f);
    // Skip hits only a set flag, and clears it
    for (int i = 0; i < 5; i++) begin
      for (int j = 0; j < 2; j++) begin
        @(posedge clk);
        skp <= 5'h1 << i;
        @(posedge clk);
        skp <= 5'h0;
        #1 check("skip", 32'((j == 0) & m[i]), oskip);
      end
    end
    // All enabled and pending: skip is inert, entries follow priority
    set_en(4'hd, 4'hc);
    pulse_src(4'hf, 1'b1);
    @(posedge clk);
    skp <= 5'h2;
    @(posedge clk);
    skp <= 5'h0;
    #1 check("inert skip", 0, oskip);
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      slow <= 1'($urandom);
      pc <= 12'($urandom);
      ctx <= 20'($urandom);
      do @(posedge clk); while (idone !== 1'b1);
      ei <= 1'b1;
      @(posedge clk);
      ei <= 1'b0;
      #1 check("early enable", 0, gie);
      cnt = -1;
      for (int t = 0; t < 80 && take !== 1'b1; t++) begin
        tick(1);
        if (cnt < 0 && gie === 1'b1) cnt = 0;
        else if (cnt >= 0 && mcyc === 1'b1) cnt++;
      end
      check("latency", 1, 32'(cnt >= exp_lat(onec) + 1 && cnt <= exp_lat(onec) + 2));
      check("entry", 1, take);
      check("vector", exp_vec(k), vec);
      check("return address", pc, raddr);
      check("saved context", ctx, octx);
      check("enable after entry", 0, gie);
      ahb(1'b0, `VIC_OFS_STATE, 0);
      check("flags left", left_after(k), rd & 32'h1f);
    end
    tick(10);
    check("restores", 5, n_rest);
    // Serial blocked by its own bit while global enable is on
    set_en(4'hd, 4'h4);
    pulse_src(4'h8, 1'b0);
    t0 = n_take;
    @(posedge clk);
    ei <= 1'b1;
    @(posedge clk);
    ei <= 1'b0;
    tick(30);
    check("global on", 1, gie);
    check("blocked take", t0, n_take);
    @(posedge clk);
    di <= 1'b1;
    @(posedge clk);
    di <= 1'b0;
    tick(1);
    check("global off", 0, gie);
    // Interrupt output: raise, mask, clear
    ahb(1'b1, `VIC_OFS_IEN, 32'h1);
    tick(3);
    check("irq raised", 1, irq);
    ahb(1'b1, `VIC_OFS_IEN, 32'h0);
    tick(3);
    check("irq masked", 0, irq);
    ahb(1'b0, `VIC_OFS_STAT, 0);
    check("status", 32'h7, rd & 32'h7);
    ahb(1'b1, `VIC_OFS_IEN, 32'h1);
    ahb(1'b1, `VIC_OFS_CLR, 32'h1);
    tick(3);
    check("irq cleared", 0, irq);
    ahb(1'b0, 8'h20, 0);
    check("unmapped", 0, rd);
    ahb(1'b0, `VIC_OFS_ENAB, 0);
    check("enables", 32'h4d, rd & 32'hff);
    check("enable ports", 32'h4d, {24'h0, en2, en1});
    print_verdict();
  end
endmodule
